// [rtc_ctrl_pkg.sv]
package rtc_ctrl_pkg;
   // register indices (byte address = index * 4 on the apb bus)
   localparam logic [6:0] IDX_REG_A = 7'h0a;
   localparam logic [6:0] IDX_REG_B = 7'h0b;
   localparam logic [6:0] IDX_REG_C = 7'h0c;
   localparam logic [6:0] IDX_REG_D = 7'h0d;
   localparam logic [6:0] IDX_SECONDS = 7'h00;
   localparam logic [6:0] IDX_SEC_ALARM = 7'h01;
   localparam logic [6:0] IDX_RAM_LO = 7'h0e;
   localparam logic [6:0] IDX_UPPER = 7'h40;
   localparam logic [6:0] IDX_EXT_4A = 7'h4a;
   localparam logic [6:0] IDX_EXT_4B = 7'h4b;
   localparam int ADDR_LSB = 2;
   localparam int NUM_CLOCK_REGS = 14;
   localparam int NUM_USER_RAM = 114;
   // register a fields
   localparam int A_UPD_BUSY = 7;
   localparam int A_OSC_HIGH = 6;
   localparam int A_OSC_MID = 5;
   localparam int A_BANK_SEL = 4;
   // register b fields
   localparam int B_SET = 7;
   localparam int B_PER_EN = 6;
   localparam int B_AIE = 5;
   localparam int B_UPD_EN = 4;
   localparam int B_SQ_EN = 3;
   // register c fields
   localparam int C_SUMMARY = 7;
   localparam int C_PER_FLAG = 6;
   localparam int C_AF = 5;
   localparam int C_UF = 4;
   // register d
   localparam int D_VRT = 7;
   // extended 4b control bits; 4a flags / 4b enables use the low three bits
   localparam int X_AUX_EN = 7;
   localparam int X_FAST_CLK = 5;
   // reset values
   localparam logic [7:0] RST_REG_A = 8'h20;
   localparam logic [7:0] RST_REG_B = 8'h08;
   // divider: 15 taps of a 32.768 kHz oscillator
   localparam int DIV_TAPS = 15;
   // alarm don't-care code in the top two bits
   localparam logic [1:0] ALARM_DC = 2'h3;
   // update timing
   localparam real CLK_MHZ = 100.0;
   localparam real LEAD_US = 244.0;
   localparam int LEAD_CYCLES = int'(LEAD_US * CLK_MHZ);
   // ticks of the 32 kHz enable per second
   localparam int OSC_PER_SEC = 32768;
endpackage

// [rtc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
   // clock
   input wire logic clk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [8:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // raised when a slave never answers
   output logic hung
);
   // idle values are a pattern, never a stale request
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 9'h155;
      pwdata = 32'ha5a5a5a5;
      hung = 1'b0;
   end

   // one byte per word; bank bit and flag clears travel as plain writes
   task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
         output logic [7:0] rd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // hold the request until pready is seen at a rising edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata[7:0];
      if (pready !== 1'b1) hung <= 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old address and data
      paddr <= ~{idx, 2'b00};
      pwdata <= ~{24'h000000, wd};
   endtask
endmodule
`default_nettype wire

// [rtc_interrupt_bank_control.sv]
// Operation
// - bank 0 shows clock regs and user RAM
// - six enables, three per control register
// - enabling a set flag asserts request immediately
// - flags set regardless of enable
// - primary flags clear on read, held during read
// - extended flags clear by writing zero
// - request low while any flag and enable
// - summary flag follows all enabled flags
// - pattern 01X runs chain, others stop
// - pattern 11X runs oscillator, chain reset
// - rate field selects divider tap multiplexer
// - square wave gated by its enable
// - fast select outputs 32 kHz clock
// - fast clock kept on auxiliary supply
// - periodic interrupt has its own enable
// - update cycle every second regardless
// - freeze holds visible copy, internal advances
// - alarm when bytes match or don't-care
// - update flag leads transfer by lead time
// - bank bit selects upper region decode
// - bank 1 replaces upper 64 RAM bytes
// - reserved bank 1 locations read zero
// - setting freeze clears update-end enable
// - periodic flag set on each rising tap edge
`timescale 1ns/1ps
`default_nettype none
module rtc_interrupt_bank_control
   import rtc_ctrl_pkg::*;
#(
   parameter int OSC_DIV = 3052,
   parameter int LEAD = LEAD_CYCLES
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CE,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [8:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // external event sources for the extended flags
   input wire logic [2:0] EXT_EVENT,
   // supply status pins
   input wire logic MAIN_BELOW_THRESHOLD,
   input wire logic AUX_SUPPLY_VALID,
   // outputs
   output logic REQUEST_N,
   output logic SQUARE_WAVE_PIN,
   output logic SQUARE_WAVE_OE
);
   typedef struct packed {
      logic [7:0] reg_a;
      logic [7:0] reg_b;
      logic [2:0] prim_flags;   // periodic, alarm, update-end
      logic [2:0] held_flags;   // events seen during a read
      logic [2:0] ext_flags;
      logic [7:0] ext_4b;
      logic [11:0] osc_cnt;
      logic osc_tick;
      logic [DIV_TAPS-1:0] chain;
      logic tap_prev;
      logic [7:0] sec_vis;
      logic [7:0] sec_int;
      logic [7:0] alarm_sec;
      logic [17:0] lead_cnt;
      logic upd_busy;
      logic freeze_prev;
      logic [2:0] ev_s1;
      logic [2:0] ev_s2;
      logic [2:0] ev_prev;
      logic [1:0] sup_s1;
      logic [1:0] sup_s2;
      logic [7:0] rdata;
      logic sq_out;
   } state_t;
   state_t st, next_st;
   logic [6:0] idx;
   logic acc, rd_acc, wr_acc;
   logic in_upper, ram_hit, bank1;
   logic [7:0] ram_rdata;
   logic tap;
   logic [2:0] pending;
   logic irq;
   logic run_chain, osc_on;
   logic [7:0] wbyte;
   logic [3:0] rs;
   logic osc_half;

   assign idx = PADDR[ADDR_LSB +: 7];
   assign acc = PSEL && PENABLE;
   assign rd_acc = acc && !PWRITE;
   assign wr_acc = acc && PWRITE;
   assign wbyte = PWDATA[7:0];
   assign bank1 = st.reg_a[A_BANK_SEL];
   assign in_upper = idx >= IDX_UPPER;
   assign ram_hit = (idx >= IDX_RAM_LO) && !(bank1 && in_upper);
   assign rs = st.reg_a[3:0];
   // oscillator and chain decode from the high and mid control bits
   assign osc_on = st.reg_a[A_OSC_MID];
   assign run_chain = osc_on && !st.reg_a[A_OSC_HIGH];
   // single cycle answer keeps the read mux and the clear in step
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign PRDATA = {24'h0, ram_hit ? ram_rdata : st.rdata};

   // user RAM: 114 bytes in bank 0, lower 50 in bank 1
   rtc_ram #(.DEPTH(128), .AW(7)) u_ram (
      .clk(REF_CLK),
      .ce(CE),
      .we(wr_acc && ram_hit),
      .waddr(idx),
      .wdata(wbyte),
      .raddr(idx),
      .rdata(ram_rdata)
   );

   // selected divider tap; codes 1 and 2 alias 8 and 9
   always_comb begin
      case (rs)
         4'h0: tap = 1'b0;
         4'h1: tap = st.chain[6];
         4'h2: tap = st.chain[7];
         4'h3: tap = st.chain[1];
         4'h4: tap = st.chain[2];
         4'h5: tap = st.chain[3];
         4'h6: tap = st.chain[4];
         4'h7: tap = st.chain[5];
         4'h8: tap = st.chain[6];
         4'h9: tap = st.chain[7];
         4'ha: tap = st.chain[8];
         4'hb: tap = st.chain[9];
         4'hc: tap = st.chain[10];
         4'hd: tap = st.chain[11];
         4'he: tap = st.chain[12];
         4'hf: tap = st.chain[13];
         default: tap = 1'b0;
      endcase
   end

   // combined request from six flag/enable pairs
   assign pending = st.prim_flags & {st.reg_b[B_PER_EN], st.reg_b[B_AIE], st.reg_b[B_UPD_EN]};
   assign irq = (|pending) || (|(st.ext_flags & st.ext_4b[2:0]));
   assign REQUEST_N = !irq;
   assign SQUARE_WAVE_PIN = st.sq_out;
   // high half of the 32 kHz enable period; a single count bit would stay low for small dividers
   assign osc_half = st.osc_cnt >= 12'(OSC_DIV / 2);
   assign SQUARE_WAVE_OE = 1'b1;

   always_comb begin
      logic [2:0] ev;
      logic [2:0] ext_rise;
      logic alarm_hit;
      ev = 3'h0;
      ext_rise = 3'h0;
      alarm_hit = 1'b0;
      next_st = st;
      // supply and event pins pass two flops first
      next_st.ev_s1 = EXT_EVENT;
      next_st.ev_s2 = st.ev_s1;
      next_st.ev_prev = st.ev_s2;
      ext_rise = st.ev_s2 & ~st.ev_prev;
      next_st.sup_s1 = {MAIN_BELOW_THRESHOLD, AUX_SUPPLY_VALID};
      next_st.sup_s2 = st.sup_s1;
      // 32 kHz enable from the reference clock, only with oscillator on
      next_st.osc_tick = 1'b0;
      if (osc_on) begin
         if (st.osc_cnt == 12'(OSC_DIV - 1)) begin
            next_st.osc_cnt = 12'h0;
            next_st.osc_tick = 1'b1;
         end else begin
            next_st.osc_cnt = st.osc_cnt + 12'h1;
         end
      end
      // countdown chain held in reset for 11x
      if (!run_chain) begin
         next_st.chain = '0;
      end else if (st.osc_tick) begin
         next_st.chain = st.chain + DIV_TAPS'(1);
      end
      // periodic edge, independent of enable
      next_st.tap_prev = tap;
      ev[2] = tap && !st.tap_prev;
      // second boundary starts update; busy flag leads the transfer
      if (run_chain && st.osc_tick && (&st.chain)) begin
         next_st.upd_busy = 1'b1;
         // loaded one short: the zero cycle itself is the last of the lead
         next_st.lead_cnt = 18'(LEAD - 1);
      end else if (st.upd_busy) begin
         if (st.lead_cnt == 18'h0) begin
            next_st.upd_busy = 1'b0;
            next_st.sec_int = st.sec_int + 8'h1;
            if (!st.reg_b[B_SET]) begin
               next_st.sec_vis = st.sec_int + 8'h1;
            end
            alarm_hit = (st.alarm_sec == st.sec_int + 8'h1)
               || (st.alarm_sec[7:6] == ALARM_DC);
            ev[1] = alarm_hit;
            ev[0] = 1'b1;
         end else begin
            next_st.lead_cnt = st.lead_cnt - 18'h1;
         end
      end
      // square wave output select; fast clock survives main loss only on aux supply
      if (st.ext_4b[X_FAST_CLK]) begin
         next_st.sq_out = (st.sup_s2[1] && !(st.ext_4b[X_AUX_EN] && st.sup_s2[0]))
            ? 1'b0 : osc_half;
      end else begin
         next_st.sq_out = st.reg_b[B_SQ_EN] && tap && !st.sup_s2[1];
      end
      // register read mux, registered on setup for the access phase
      next_st.rdata = 8'h0;
      if (PSEL && !PENABLE) begin
         case (idx)
            IDX_REG_A: next_st.rdata = {st.upd_busy, st.reg_a[6:0]};
            IDX_REG_B: next_st.rdata = st.reg_b;
            IDX_REG_C: next_st.rdata = {irq, st.prim_flags, 4'h0};
            IDX_REG_D: next_st.rdata[D_VRT] = 1'b1;
            IDX_SECONDS: next_st.rdata = st.sec_vis;
            IDX_SEC_ALARM: next_st.rdata = st.alarm_sec;
            default: begin
               if (bank1 && idx == IDX_EXT_4A) begin
                  next_st.rdata = {5'h0, st.ext_flags};
               end else if (bank1 && idx == IDX_EXT_4B) begin
                  next_st.rdata = st.ext_4b;
               end else begin
                  next_st.rdata = 8'h0;
               end
            end
         endcase
      end
      // register writes
      if (wr_acc) begin
         case (idx)
            IDX_REG_A: next_st.reg_a = {1'b0, wbyte[6:0]};
            IDX_REG_B: next_st.reg_b = wbyte;
            IDX_SECONDS: begin
               next_st.sec_vis = wbyte;
               next_st.sec_int = wbyte;
            end
            IDX_SEC_ALARM: next_st.alarm_sec = wbyte;
            default: begin
               if (bank1 && idx == IDX_EXT_4A) begin
                  next_st.ext_flags = st.ext_flags & wbyte[2:0];
               end else if (bank1 && idx == IDX_EXT_4B) begin
                  next_st.ext_4b = wbyte;
               end
            end
         endcase
      end
      // freeze rising clears update-end enable
      next_st.freeze_prev = next_st.reg_b[B_SET];
      if (next_st.reg_b[B_SET] && !st.freeze_prev) begin
         next_st.reg_b[B_UPD_EN] = 1'b0;
      end
      // extended flags: set wins over clear
      next_st.ext_flags = next_st.ext_flags | ext_rise;
      // primary flags: events during a read are held, posted after
      if (rd_acc && idx == IDX_REG_C) begin
         next_st.prim_flags = st.held_flags | ev;
         next_st.held_flags = 3'h0;
      end else if (PSEL && idx == IDX_REG_C && !PWRITE) begin
         next_st.held_flags = st.held_flags | ev;
      end else begin
         next_st.prim_flags = st.prim_flags | st.held_flags | ev;
         next_st.held_flags = 3'h0;
      end
   end

   // single state register; enable freezes everything
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         st <= '0;
         st.reg_a <= RST_REG_A;
         st.reg_b <= RST_REG_B;
      end else if (CE) begin
         st <= next_st;
      end
   end

   property p_req_tracks;
      @(posedge REF_CLK) disable iff (RESET) (|pending) |-> !REQUEST_N;
   endproperty
   a_req_tracks: assert property (p_req_tracks) else $error("request not low");

   property p_chain_reset;
      @(posedge REF_CLK) disable iff (RESET) (CE && !run_chain) |=> (st.chain == '0);
   endproperty
   a_chain_reset: assert property (p_chain_reset) else $error("chain not held");

   property p_uie_clear;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && $rose(st.reg_b[B_SET])) |-> !st.reg_b[B_UPD_EN];
   endproperty
   a_uie_clear: assert property (p_uie_clear) else $error("update enable kept");

   property p_ext_sticky;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && st.ext_flags[0] && !wr_acc) |=> st.ext_flags[0];
   endproperty
   a_ext_sticky: assert property (p_ext_sticky) else $error("ext flag lost");

   property p_pf_edge;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && tap && !st.tap_prev && !PSEL) |=> st.prim_flags[2];
   endproperty
   a_pf_edge: assert property (p_pf_edge) else $error("periodic flag missed");

   property p_rc_clear;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && rd_acc && idx == IDX_REG_C) |=> (st.held_flags == 3'h0);
   endproperty
   a_rc_clear: assert property (p_rc_clear) else $error("hold not posted");

   property p_fast_sq;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && st.ext_4b[X_FAST_CLK] && !st.sup_s2[1]) |=> (st.sq_out == $past(osc_half));
   endproperty
   a_fast_sq: assert property (p_fast_sq) else $error("fast clock wrong");

   property p_sq_off;
      @(posedge REF_CLK) disable iff (RESET)
         (CE && !st.ext_4b[X_FAST_CLK] && !st.reg_b[B_SQ_EN]) |=> !st.sq_out;
   endproperty
   a_sq_off: assert property (p_sq_off) else $error("square wave not off");
endmodule
`default_nettype wire

// [rtc_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_ram #(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // clock
   input wire logic clk,
   input wire logic ce,
   // write
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // read, registered
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];
   // write and registered read share a port-free clocked process
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// [tb_rtc_interrupt_bank_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_interrupt_bank_control
   import rtc_ctrl_pkg::*;
;
   localparam int LEAD_T = 8;
   logic ref_clk;
   logic reset;
   logic [2:0] ext_event;
   logic main_below;
   logic aux_valid;
   logic psel;
   logic penable;
   logic pwrite;
   logic [8:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic request_n;
   logic sq_pin;
   logic sq_oe;
   logic hung;
   logic [7:0] val;
   logic [7:0] sec0;
   int mismatches;
   int checked;
   int cnt;
   int exp;

   // short divider and lead keep one second near 65k cycles
   rtc_interrupt_bank_control #(.OSC_DIV(2), .LEAD(LEAD_T)) dut (.REF_CLK(ref_clk),
      .RESET(reset), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EXT_EVENT(ext_event), .MAIN_BELOW_THRESHOLD(main_below),
      .AUX_SUPPLY_VALID(aux_valid), .REQUEST_N(request_n), .SQUARE_WAVE_PIN(sq_pin),
      .SQUARE_WAVE_OE(sq_oe));
   rtc_host_model host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .hung(hung));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic [7:0] dummy;
      host.xfer(1'b1, idx, d, dummy);
   endtask

   task automatic rd(input logic [6:0] idx, output logic [7:0] d);
      host.xfer(1'b0, idx, 8'h00, d);
   endtask

   // request line is combinational, so look once the edge has landed
   task automatic irq_chk(input logic want);
      @(negedge ref_clk);
      check({7'h00, request_n}, {7'h00, want});
   endtask

   task automatic count_tog(input int n, output int c);
      logic last;
      c = 0;
      // the pin is registered behind the chain, so let a write settle first
      repeat (4) @(posedge ref_clk);
      last = sq_pin;
      repeat (n) begin
         @(posedge ref_clk);
         if (sq_pin !== last) c++;
         last = sq_pin;
      end
   endtask

   // a bus that never answers ends the run
   always @(posedge ref_clk) begin
      if (hung === 1'b1) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      mismatches = 0;
      checked = 0;
      reset = 1'b1;
      ext_event = 3'h0;
      main_below = 1'b0;
      aux_valid = 1'b0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      rd(IDX_REG_A, val);
      check(val, RST_REG_A);
      rd(IDX_REG_B, val);
      check(val, RST_REG_B);
      rd(IDX_REG_C, val);
      check(val, 8'h00);
      // bank 0 lower and upper user ram, then bank 1 keeps lower ram and reads zero above
      wr(IDX_UPPER, 8'ha5);
      wr(IDX_RAM_LO, 8'h3c);
      wr(7'h7f, 8'h5a);
      rd(IDX_UPPER, val);
      check(val, 8'ha5);
      rd(7'h7f, val);
      check(val, 8'h5a);
      wr(IDX_REG_A, RST_REG_A | 8'h10);
      rd(IDX_RAM_LO, val);
      check(val, 8'h3c);
      rd(IDX_UPPER, val);
      check(val, 8'h00);
      wr(7'h4c, 8'hff);
      rd(7'h4c, val);
      check(val, 8'h00);
      check({7'h00, pslverr}, 8'h00);
      // each extended source: poll, enable, write-one, write-zero
      for (int i = 0; i < 3; i++) begin
         ext_event[i] <= 1'b1;
         repeat (4) @(posedge ref_clk);
         ext_event[i] <= 1'b0;
         repeat (4) @(posedge ref_clk);
         rd(IDX_EXT_4A, val);
         check(val & 8'h07, 8'h01 << i);
         irq_chk(1'b1);
         wr(IDX_EXT_4B, 8'h01 << i);
         irq_chk(1'b0);
         rd(IDX_REG_C, val);
         check(val & 8'h80, 8'h80);
         rd(IDX_EXT_4A, val);
         wr(IDX_EXT_4A, 8'hff);
         rd(IDX_EXT_4A, val);
         check(val & 8'h07, 8'h01 << i);
         wr(IDX_EXT_4A, 8'h00);
         irq_chk(1'b1);
         rd(IDX_REG_C, val);
         check(val & 8'h80, 8'h00);
         wr(IDX_EXT_4B, 8'h00);
      end
      // fast clock ignores the rate field, also on auxiliary supply
      wr(IDX_EXT_4B, 8'h20);
      count_tog(64, cnt);
      check({7'h00, cnt > 8}, 8'h01);
      main_below <= 1'b1;
      aux_valid <= 1'b1;
      wr(IDX_EXT_4B, 8'ha0);
      count_tog(64, cnt);
      check({7'h00, cnt > 8}, 8'h01);
      wr(IDX_EXT_4B, 8'h20);
      count_tog(64, cnt);
      check({7'h00, cnt == 0}, 8'h01);
      wr(IDX_EXT_4B, 8'h00);
      main_below <= 1'b0;
      // 8.192 kHz toggles every 4 cycles at this divider, each rate halves it
      for (int r = 3; r <= 6; r++) begin
         wr(IDX_REG_A, 8'h20 | r[7:0]);
         count_tog(256, cnt);
         exp = 256 >> (r - 1);
         check({7'h00, cnt >= exp - 1 && cnt <= exp + 1}, 8'h01);
      end
      wr(IDX_REG_B, 8'h00);
      count_tog(64, cnt);
      check({7'h00, cnt == 0 && sq_pin === 1'b0}, 8'h01);
      check({7'h00, sq_oe}, 8'h01);
      wr(IDX_REG_B, 8'h08);
      wr(IDX_REG_A, 8'h03);
      count_tog(64, cnt);
      check({7'h00, cnt == 0}, 8'h01);
      wr(IDX_REG_A, 8'h63);
      count_tog(64, cnt);
      check({7'h00, cnt == 0}, 8'h01);
      // periodic flag without its enable, then read-clear
      wr(IDX_REG_A, 8'h23);
      rd(IDX_REG_C, val);
      repeat (20) @(posedge ref_clk);
      irq_chk(1'b1);
      wr(IDX_REG_A, 8'h20);
      rd(IDX_REG_C, val);
      check(val & 8'h40, 8'h40);
      rd(IDX_REG_C, val);
      check(val & 8'h40, 8'h00);
      wr(IDX_REG_A, 8'h23);
      wr(IDX_REG_B, 8'h48);
      cnt = 0;
      while (request_n !== 1'b0 && cnt < 32) begin
         @(negedge ref_clk);
         cnt++;
      end
      check({7'h00, request_n}, 8'h00);
      wr(IDX_REG_B, 8'h08);
      wr(IDX_REG_A, 8'h20);
      rd(IDX_REG_C, val);
      // freeze clears the update enable; alarm byte set to don't-care
      wr(IDX_REG_B, 8'h98);
      rd(IDX_REG_B, val);
      check(val, 8'h88);
      wr(7'h01, 8'hc0);
      rd(7'h00, sec0);
      cnt = 0;
      val = 8'h00;
      while (val[7] !== 1'b1 && cnt < 25000) begin
         rd(IDX_REG_A, val);
         cnt++;
      end
      check(val & 8'h80, 8'h80);
      repeat (LEAD_T + 4) @(posedge ref_clk);
      rd(7'h00, val);
      check(val, sec0);
      rd(IDX_REG_C, val);
      check(val & 8'h30, 8'h30);
      close_out();
   end
endmodule
`default_nettype wire
